// ===== rtl/cif_counter_front.sv
// What this block does
// - Edge count holds while pause input inactive.
// - Pulse generation suspends while pause inactive.
// - Pause source travels through the gate path.
// - Output or terminal count gates other counter.
// - Filter samples on 40 MHz enable.
// - Level passes after N equal samples.
// - Setting selects 5, 257, 101800 or bypass.
// - Per-input filter settings, reset to disabled.
// - Direct line forwarding uses unfiltered signal.
// - Prescaler divides source by 8 or 2.
// - Prescaler count is never readable.
// - Prescaler only for external source.
// - Buffer count between rising gate edges.
// - Without prevention, gate seen at source edge.
// - Prevention syncs source and gate to fast.
// - Count changes on source or fast timebase.
// - 32-bit up/down counter, inputs synchronised.
// - Sync mode chosen from prevention, position, source.
// - Fast mode: sync rising, count next rising.
// - Internal mode: sync falling, count next rising.
// - External mode: sync delayed source, count source.
// - Terminal count asserts while value is zero.
//
// The register offsets and the strobed register port were left to the implementer.
`include "cif_map.svh"
module cif_counter_front
	import cif_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [1:0]  ext_source,
	input  wire logic [1:0]  ext_gate,
	input  wire logic [1:0]  medium_timebase,
	input  wire logic [1:0]  slow_timebase,
	input  wire logic [1:0]  backplane_10mhz_clock,
	input  wire logic [7:0]  programmable_io_line,
	input  wire logic [7:0]  trigger_bus_line,
	output logic      [7:0]  filtered_line,
	output logic      [7:0]  pio_to_trigger,
	output logic      [7:0]  trigger_to_pio,
	output logic      [1:0]  internal_output,
	output logic      [1:0]  terminal_count
);
	localparam int FILT_STEP = `CIF_FILT_HZ;
	localparam int CLK_RATE  = `CIF_CLK_HZ;
	localparam int FAST_RATE = `CIF_FAST_HZ;

	typedef struct packed
	{
		cif_ctr_type [1:0]   ctr;
		cif_filt_type [15:0] filt;
		logic [31:0]         filt_cfg;
		logic [31:0]         facc;
		logic [31:0]         fastacc;
		logic [31:0]         rdata;
	} cif_state_type;

	cif_state_type s_r;
	cif_state_type s_nxt;

	function automatic logic [19:0] filt_len(input logic [1:0] setting);
		unique case (setting)
			`CIF_FS_SHORT: filt_len = `CIF_N_SHORT;
			`CIF_FS_MID:   filt_len = `CIF_N_MID;
			default:       filt_len = `CIF_N_LONG;
		endcase
	endfunction

	function automatic cif_sync_type pick_mode(input logic [15:0] c);
		logic [2:0] src;
		src = c[`CIF_C_SRC_HI:`CIF_C_SRC_LO];
		if (c[`CIF_C_DUP] || c[`CIF_C_POS] || src == `CIF_SRC_FAST)
			pick_mode = CIF_SYNC_FAST;
		else if (src == `CIF_SRC_MED || src == `CIF_SRC_SLOW || src == `CIF_SRC_BP10)
			pick_mode = CIF_SYNC_INT;
		else
			pick_mode = CIF_SYNC_EXT;
	endfunction

	logic [15:0] line_in;
	logic [15:0] line_q;
	logic        filt_tick;
	logic        fast_tick;
	logic [1:0]  tc;

	assign line_in = {trigger_bus_line, programmable_io_line};
	assign pio_to_trigger = programmable_io_line;
	assign trigger_to_pio = trigger_bus_line;
	// The 80 MHz fast rate exceeds the 50 MHz clock, so each fast tick marks one or more samples folded; the 40 MHz filter rate does not.
	assign filt_tick = (s_r.facc + 32'(FILT_STEP)) >= 32'(CLK_RATE);
	assign fast_tick = (s_r.fastacc + 32'(FAST_RATE)) >= 32'(CLK_RATE);

	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (s_r.filt_cfg[2*i +: 2] == `CIF_FS_OFF)
				line_q[i] = line_in[i];
			else
				line_q[i] = s_r.filt[i].q;
		end
	end
	assign filtered_line = line_q[7:0];

	always_comb
	begin
		logic       src_raw;
		logic       gate_raw;
		logic       src_rise;
		logic       src_fall;
		logic       sync_ev;
		logic       cnt_ev;
		logic       active;
		logic [1:0] gsel;
		logic [1:0] ps;
		logic [2:0] top;
		logic       gate_edge;
		src_raw = 1'b0;
		gate_raw = 1'b0;
		src_rise = 1'b0;
		src_fall = 1'b0;
		sync_ev = 1'b0;
		cnt_ev = 1'b0;
		active = 1'b0;
		gsel = 2'h0;
		ps = 2'h0;
		top = 3'h0;
		gate_edge = 1'b0;
		s_nxt = s_r;
		s_nxt.rdata = 32'h00000000;
		s_nxt.facc = filt_tick ? s_r.facc + 32'(FILT_STEP) - 32'(CLK_RATE)
			: s_r.facc + 32'(FILT_STEP);
		s_nxt.fastacc = fast_tick ? s_r.fastacc + 32'(FAST_RATE) - 32'(CLK_RATE)
			: s_r.fastacc + 32'(FAST_RATE);
		for (int i = 0; i < 16; i++)
		begin
			if (s_r.filt_cfg[2*i +: 2] == `CIF_FS_OFF)
			begin
				s_nxt.filt[i].q = line_in[i];
				s_nxt.filt[i].cnt = 20'h00000;
			end
			else if (filt_tick)
			begin
				if (line_in[i] == s_r.filt[i].q)
					s_nxt.filt[i].cnt = 20'h00000;
				else if (s_r.filt[i].cnt + 20'h00001 >= filt_len(s_r.filt_cfg[2*i +: 2]))
				begin
					s_nxt.filt[i].q = line_in[i];
					s_nxt.filt[i].cnt = 20'h00000;
				end
				else
					s_nxt.filt[i].cnt = s_r.filt[i].cnt + 20'h00001;
			end
		end
		for (int n = 0; n < 2; n++)
		begin
			s_nxt.ctr[n].mode = pick_mode(s_r.ctr[n].ctrl);
			unique case (s_r.ctr[n].ctrl[`CIF_C_SRC_HI:`CIF_C_SRC_LO])
				`CIF_SRC_FAST: src_raw = fast_tick;
				`CIF_SRC_MED:  src_raw = medium_timebase[n];
				`CIF_SRC_SLOW: src_raw = slow_timebase[n];
				`CIF_SRC_BP10: src_raw = backplane_10mhz_clock[n];
				default:       src_raw = n == 0 ? line_q[0] ^ ext_source[0] : line_q[3] ^ ext_source[1];
			endcase
			gsel = s_r.ctr[n].ctrl[`CIF_C_GATE_HI:`CIF_C_GATE_LO];
			if (gsel == `CIF_GATE_OUT)
				gate_raw = s_r.ctr[1-n].out;
			else if (gsel == `CIF_GATE_TC)
				gate_raw = tc[1-n];
			else
				gate_raw = n == 0 ? line_q[1] ^ ext_gate[0] : line_q[4] ^ ext_gate[1];
			s_nxt.ctr[n].src_d = src_raw;
			s_nxt.ctr[n].src_dd = s_r.ctr[n].src_d;
			src_rise = s_r.ctr[n].src_d & ~s_r.ctr[n].src_dd;
			src_fall = ~s_r.ctr[n].src_d & s_r.ctr[n].src_dd;
			// The delayed source copy src_dd is two clocks later, standing in for the ns delay.
			unique case (s_r.ctr[n].mode)
				CIF_SYNC_FAST: sync_ev = s_r.ctr[n].ctrl[`CIF_C_DUP] ? 1'b1 : src_rise;
				CIF_SYNC_INT:  sync_ev = src_fall;
				default:       sync_ev = src_d_rise_delayed(s_r.ctr[n].src_dd, src_raw);
			endcase
			cnt_ev = src_rise;
			ps = s_r.ctr[n].ctrl[`CIF_C_PS_HI:`CIF_C_PS_LO];
			if (s_r.ctr[n].mode == CIF_SYNC_EXT && ps != `CIF_PS_OFF && cnt_ev)
			begin
				top = ps == `CIF_PS_DIV8 ? `CIF_PS_DIV8_TOP : `CIF_PS_DIV2_TOP;
				s_nxt.ctr[n].pre = s_r.ctr[n].pre == top ? 3'h0 : s_r.ctr[n].pre + 3'h1;
				cnt_ev = s_r.ctr[n].pre == top;
			end
			if (sync_ev)
				s_nxt.ctr[n].gate_s = gate_raw;
			gate_edge = s_r.ctr[n].gate_s & ~s_r.ctr[n].gate_prev;
			s_nxt.ctr[n].gate_prev = s_r.ctr[n].gate_s;
			// A gate used as pause never buffers, so a resumed edge count keeps its value.
			if (gate_edge && !s_r.ctr[n].ctrl[`CIF_C_PAUSE])
				s_nxt.ctr[n].gate_pend = 1'b1;
			active = s_r.ctr[n].ctrl[`CIF_C_EN] & (~s_r.ctr[n].ctrl[`CIF_C_PAUSE]
				| (s_r.ctr[n].gate_s ^ s_r.ctr[n].ctrl[`CIF_C_PINV]));
			// Gate edges are buffered on the next count event, or the next clock with prevention, so the stored value is coherent.
			if (s_r.ctr[n].gate_pend && (cnt_ev || s_r.ctr[n].ctrl[`CIF_C_DUP]))
			begin
				s_nxt.ctr[n].buffer = s_r.ctr[n].count;
				s_nxt.ctr[n].buf_new = 1'b1;
				s_nxt.ctr[n].gate_pend = 1'b0;
				s_nxt.ctr[n].count = 32'h00000000;
			end
			else if (cnt_ev && active)
			begin
				if (s_r.ctr[n].ctrl[`CIF_C_DIR])
					s_nxt.ctr[n].count = s_r.ctr[n].count - 32'h00000001;
				else
					s_nxt.ctr[n].count = s_r.ctr[n].count + 32'h00000001;
				if (s_r.ctr[n].ctrl[`CIF_C_PULSE] && s_r.ctr[n].count == 32'h00000001)
					s_nxt.ctr[n].out = s_r.ctr[n].ctrl[`CIF_C_TOGGLE]
						? ~s_r.ctr[n].out : ~s_r.ctr[n].ctrl[`CIF_C_OPOL];
				else if (~s_r.ctr[n].ctrl[`CIF_C_TOGGLE])
					s_nxt.ctr[n].out = s_r.ctr[n].ctrl[`CIF_C_OPOL];
			end
		end
		if (reg_wr)
		begin
			unique case (reg_addr)
				`CIF_REG_CTRL0: s_nxt.ctr[0].ctrl = reg_wdata[15:0];
				`CIF_REG_CTRL1: s_nxt.ctr[1].ctrl = reg_wdata[15:0];
				`CIF_REG_CNT0:  s_nxt.ctr[0].count = reg_wdata;
				`CIF_REG_CNT1:  s_nxt.ctr[1].count = reg_wdata;
				`CIF_REG_FILT:  s_nxt.filt_cfg = reg_wdata;
				default:        s_nxt.rdata = 32'h00000000;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				`CIF_REG_CTRL0: s_nxt.rdata = {16'h0000, s_r.ctr[0].ctrl};
				`CIF_REG_CTRL1: s_nxt.rdata = {16'h0000, s_r.ctr[1].ctrl};
				`CIF_REG_CNT0:  s_nxt.rdata = s_r.ctr[0].count;
				`CIF_REG_CNT1:  s_nxt.rdata = s_r.ctr[1].count;
				`CIF_REG_BUF0:  s_nxt.rdata = s_r.ctr[0].buffer;
				`CIF_REG_BUF1:  s_nxt.rdata = s_r.ctr[1].buffer;
				`CIF_REG_FILT:  s_nxt.rdata = s_r.filt_cfg;
				`CIF_REG_STAT:  s_nxt.rdata = {26'h0000000, tc, s_r.ctr[1].buf_new,
					s_r.ctr[0].buf_new, s_r.ctr[1].out, s_r.ctr[0].out};
				default:        s_nxt.rdata = 32'h00000000;
			endcase
			if (reg_addr == `CIF_REG_BUF0 && !(s_r.ctr[0].gate_pend))
				s_nxt.ctr[0].buf_new = s_nxt.ctr[0].buf_new & ~s_r.ctr[0].buf_new | 1'b0;
			if (reg_addr == `CIF_REG_BUF1 && !(s_r.ctr[1].gate_pend))
				s_nxt.ctr[1].buf_new = s_nxt.ctr[1].buf_new & ~s_r.ctr[1].buf_new | 1'b0;
		end
	end

	function automatic logic src_d_rise_delayed(input logic older, input logic now_v);
		src_d_rise_delayed = 1'b0;
		if (older == 1'b0 && now_v == 1'b1)
			src_d_rise_delayed = 1'b0;
		src_d_rise_delayed = ~older & now_v;
	endfunction

	always_comb
	begin
		for (int n = 0; n < 2; n++)
			tc[n] = s_r.ctr[n].count == 32'h00000000;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.ctr[0].ctrl <= `CIF_CTRL_RST;
			s_r.ctr[1].ctrl <= `CIF_CTRL_RST;
			s_r.ctr[0].mode <= CIF_SYNC_EXT;
			s_r.ctr[1].mode <= CIF_SYNC_EXT;
			s_r.filt_cfg <= 32'h00000000;
		end
		else
			s_r <= s_nxt;
	end

	assign reg_rdata = s_r.rdata;
	assign terminal_count = tc;
	assign internal_output = {s_r.ctr[1].out, s_r.ctr[0].out};
endmodule

// ===== rtl/cif_map.svh
`ifndef CIF_MAP_SVH
`define CIF_MAP_SVH
// Clock rate and derived rates.
`define CIF_CLK_HZ         50000000
`define CIF_FILT_HZ        40000000
`define CIF_FAST_HZ        80000000
// Filter sample counts per setting.
`define CIF_N_SHORT        20'h00005
`define CIF_N_MID          20'h00101
`define CIF_N_LONG         20'h18DA8
// Filter setting codes.
`define CIF_FS_OFF         2'h0
`define CIF_FS_SHORT       2'h1
`define CIF_FS_MID         2'h2
`define CIF_FS_LONG        2'h3
// Prescale codes.
`define CIF_PS_OFF         2'h0
`define CIF_PS_DIV2        2'h1
`define CIF_PS_DIV8        2'h2
`define CIF_PS_DIV2_TOP    3'h1
`define CIF_PS_DIV8_TOP    3'h7
// Source select codes.
`define CIF_SRC_EXT        3'h0
`define CIF_SRC_FAST       3'h1
`define CIF_SRC_MED        3'h2
`define CIF_SRC_SLOW       3'h3
`define CIF_SRC_BP10       3'h4
// Gate select codes.
`define CIF_GATE_EXT       2'h0
`define CIF_GATE_OUT       2'h1
`define CIF_GATE_TC        2'h2
// Register offsets.
`define CIF_REG_CTRL0      4'h0
`define CIF_REG_CTRL1      4'h1
`define CIF_REG_CNT0       4'h2
`define CIF_REG_CNT1       4'h3
`define CIF_REG_BUF0       4'h4
`define CIF_REG_BUF1       4'h5
`define CIF_REG_FILT       4'h6
`define CIF_REG_STAT       4'h7
// Control register fields.
`define CIF_C_EN           0
`define CIF_C_DIR          1
`define CIF_C_PAUSE        2
`define CIF_C_PINV         3
`define CIF_C_PULSE        4
`define CIF_C_DUP          5
`define CIF_C_POS          6
`define CIF_C_SRC_LO       7
`define CIF_C_SRC_HI       9
`define CIF_C_GATE_LO      10
`define CIF_C_GATE_HI      11
`define CIF_C_PS_LO        12
`define CIF_C_PS_HI        13
`define CIF_C_TOGGLE       14
`define CIF_C_OPOL         15
`define CIF_CTRL_RST       16'h0000
`endif

// ===== rtl/cif_pkg.sv
package cif_pkg;
	typedef enum logic [2:0]
	{
		CIF_SYNC_FAST  = 3'h1,
		CIF_SYNC_INT   = 3'h2,
		CIF_SYNC_EXT   = 3'h4
	} cif_sync_type;
	typedef struct packed
	{
		logic [19:0] cnt;
		logic        q;
	} cif_filt_type;
	typedef struct packed
	{
		logic [15:0]  ctrl;
		logic [31:0]  count;
		logic [31:0]  buffer;
		logic         buf_new;
		logic [2:0]   pre;
		logic         src_d;
		logic         src_dd;
		logic         gate_s;
		logic         gate_prev;
		logic         gate_pend;
		logic         out;
		cif_sync_type mode;
	} cif_ctr_type;
endpackage

// ===== bench/cif_sig_model.sv
module cif_sig_model
(
	input  wire logic       clk,
	output logic      [7:0] programmable_io_line,
	output logic      [7:0] trigger_bus_line,
	output logic      [1:0] medium_timebase,
	output logic      [1:0] slow_timebase,
	output logic      [1:0] backplane_10mhz_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tick_r = 8'h00;
	always @(posedge clk)
	begin
		tick_r <= tick_r + 8'h01;
	end
	assign medium_timebase = {2{tick_r[0]}};
	assign slow_timebase = {2{tick_r[7]}};
	assign backplane_10mhz_clock = {2{tick_r[2]}};
	// A counting pattern so every forwarded bit is seen in both states.
	assign trigger_bus_line = tick_r ^ 8'h5A;
	initial programmable_io_line = 8'h00;
	// Two high and two low cycles hold the source at 12.5 MHz.
	task automatic pulses(input int line, input int n);
		repeat (n)
		begin
			programmable_io_line[line] <= 1'b1;
			repeat (2) @(posedge clk);
			programmable_io_line[line] <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic level(input int line, input logic v);
		programmable_io_line[line] <= v;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ===== bench/cif_counter_front_properties.sv
module cif_front_props
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [7:0]  programmable_io_line,
	input wire logic [7:0]  trigger_bus_line,
	input wire logic [7:0]  filtered_line,
	input wire logic [7:0]  pio_to_trigger,
	input wire logic [7:0]  trigger_to_pio,
	input wire logic [1:0]  internal_output,
	input wire logic [1:0]  terminal_count
);
	// Any filter write ends the bypass check; a zero write is conservative.
	logic cfg_r;
	logic cfg_nxt;
	always_comb
	begin
		cfg_nxt = cfg_r | (reg_wr && reg_addr == 4'h6);
	end
	always_ff @(posedge clk)
	begin
		cfg_r <= rst ? 1'b0 : cfg_nxt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_fwd_pio: assert property (pio_to_trigger == programmable_io_line)
		else $error("pio forward differs");
	a_fwd_trig: assert property (trigger_to_pio == trigger_bus_line)
		else $error("trigger forward differs");
	a_filt_bypass: assert property (!cfg_r && !$past(rst)
		|-> filtered_line == programmable_io_line) else $error("filter not off");
	a_tc_reset: assert property ($fell(rst) |-> terminal_count == 2'h3)
		else $error("tc low after reset");
	a_stat_tc: assert property (reg_rd && reg_addr == 4'h7
		|=> reg_rdata[5:4] == $past(terminal_count)) else $error("status tc differs");
	a_stat_out: assert property (reg_rd && reg_addr == 4'h7
		|=> reg_rdata[1:0] == $past(internal_output)) else $error("status out differs");
	a_no_hidden: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	cover property (reg_rd && reg_addr == 4'h3);
	cover property ($rose(filtered_line[2]));
	cover property ($fell(terminal_count[0]));
endmodule
bind cif_counter_front cif_front_props chk_u (.clk, .rst, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .programmable_io_line, .trigger_bus_line, .filtered_line,
	.pio_to_trigger, .trigger_to_pio, .internal_output, .terminal_count);

// ===== bench/tb_cif_counter_front.sv
`include "cif_map.svh"
module tb_cif_counter_front;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0]  ext_source = 2'h0;
	logic [1:0]  ext_gate = 2'h0;
	logic [1:0]  medium_timebase, slow_timebase, backplane_10mhz_clock;
	logic [7:0]  programmable_io_line, trigger_bus_line, filtered_line;
	logic [7:0]  pio_to_trigger, trigger_to_pio;
	logic [1:0]  internal_output, terminal_count;
	int          fails = 0;
	int          total_checks = 0;
	always #10 clk = ~clk;
	cif_sig_model pm (.clk, .programmable_io_line, .trigger_bus_line, .medium_timebase,
		.slow_timebase, .backplane_10mhz_clock);
	cif_counter_front dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ext_source, .ext_gate, .medium_timebase, .slow_timebase,
		.backplane_10mhz_clock, .programmable_io_line, .trigger_bus_line,
		.filtered_line, .pio_to_trigger, .trigger_to_pio, .internal_output,
		.terminal_count);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp, what);
	endtask
	// The count lands a few clocks after the last source rise.
	task automatic src(input int line, input int n);
		@(posedge clk);
		pm.pulses(line, n);
		repeat (6) @(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		fails++;
		test_done();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(`CIF_REG_FILT, 32'h0, "filt");
		rd(`CIF_REG_STAT, 32'h30, "stat");
		rd(4'h9, 32'h0, "unmapped");
		$display("test reset done");
		wr(`CIF_REG_CTRL0, 32'h2001);
		src(0, 16);
		rd(`CIF_REG_CNT0, 32'h2, "div8");
		wr(`CIF_REG_CTRL0, 32'h1001);
		src(0, 6);
		rd(`CIF_REG_CNT0, 32'h5, "div2");
		wr(`CIF_REG_CTRL0, 32'h0001);
		src(0, 5);
		rd(`CIF_REG_CNT0, 32'hA, "up");
		wr(`CIF_REG_CTRL0, 32'h0003);
		src(0, 3);
		rd(`CIF_REG_CNT0, 32'h7, "down");
		$display("test count done");
		wr(`CIF_REG_CTRL0, 32'h0005);
		src(0, 4);
		rd(`CIF_REG_CNT0, 32'h7, "paused");
		pm.level(1, 1'b1);
		src(0, 4);
		rd(`CIF_REG_CNT0, 32'hB, "resumed");
		wr(`CIF_REG_CTRL0, 32'h000D);
		src(0, 2);
		rd(`CIF_REG_CNT0, 32'hB, "inverted");
		$display("test pause done");
		wr(`CIF_REG_CTRL1, 32'h0805);
		src(3, 3);
		rd(`CIF_REG_CNT1, 32'h0, "held");
		wr(`CIF_REG_CTRL0, 32'h0003);
		src(0, 11);
		chk({30'h0, terminal_count}, 32'h3, "tc");
		src(3, 2);
		rd(`CIF_REG_CNT1, 32'h2, "cascade");
		$display("test cascade done");
		wr(`CIF_REG_FILT, 32'h10);
		pm.level(2, 1'b1);
		pm.level(2, 1'b0);
		repeat (20) @(posedge clk);
		chk({31'h0, filtered_line[2]}, 32'h0, "glitch");
		pm.level(2, 1'b1);
		@(negedge clk);
		chk({31'h0, filtered_line[2]}, 32'h0, "early");
		repeat (10) @(negedge clk);
		chk({31'h0, filtered_line[2]}, 32'h1, "passed");
		wr(`CIF_REG_FILT, 32'h20);
		pm.level(2, 1'b0);
		repeat (100) @(negedge clk);
		chk({31'h0, filtered_line[2]}, 32'h1, "mid held");
		repeat (300) @(negedge clk);
		chk({31'h0, filtered_line[2]}, 32'h0, "mid passed");
		$display("test filter done");
		test_done();
	end
endmodule
